// *** cfd_core.sv ***
// fetch unit, register file, alu and data space decoder
`timescale 1ns/1ps
`default_nettype none
module cfd_core
    import cfd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    output logic [23:0] prog_addr,
    output logic prog_rd,
    input wire logic [15:0] prog_data,
    input wire logic [1:0] app_lock,
    input wire logic [1:0] table_lock,
    input wire logic [1:0] boot_lock,
    input wire logic exec_valid,
    input wire logic [3:0] exec_op,
    input wire logic exec_imm_sel,
    input wire logic [7:0] exec_imm,
    input wire logic [4:0] exec_rd,
    input wire logic [4:0] exec_rr,
    input wire logic [1:0] ptr_sel,
    output logic [15:0] ptr_value,
    input wire logic [23:0] data_addr,
    input wire logic data_req,
    input wire logic data_direct_io,
    output logic sel_io,
    output logic sel_nvm_win,
    output logic sel_sram,
    output logic sel_ext_ram,
    output logic data_refused,
    input wire logic self_program_store_op_req,
    input wire logic [23:0] self_program_store_op_addr,
    output logic self_program_store_op_grant,
    output logic prog_rd_blocked,
    output logic [15:0] instr_q,
    output logic instr_valid_q,
    output logic [7:0] flags_q
);
    cfd_state_t state_q;
    logic [23:0] pc_q;
    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [8:0] res_d;
    logic [4:0] ptr_idx;
    logic fetch_ok;
    logic in_io;
    logic in_nvm;
    logic in_sram;
    logic [1:0] fetch_lock;
    logic [1:0] store_lock;

    function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [1:0] lock_for(input logic [23:0] a, input logic [1:0] al,
                                            input logic [1:0] tl, input logic [1:0] bl);
        if (a >= BOOT_FIRST)
            lock_for = bl;
        else if (a >= APP_TABLE_FIRST)
            lock_for = tl;
        else
            lock_for = al;
    endfunction

    // fetch from program memory only; own bus separate from data
    assign prog_addr = pc_q;
    assign fetch_lock = lock_for(pc_q, app_lock, table_lock, boot_lock);
    assign fetch_ok = !fetch_lock[LOCK_RW];
    assign prog_rd = (state_q != CFD_STATE_RESET) && fetch_ok;
    assign prog_rd_blocked = (state_q != CFD_STATE_RESET) && !fetch_ok;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            state_q <= CFD_STATE_RESET;
        else
        begin
            unique case (state_q)
                CFD_STATE_RESET: state_q <= CFD_STATE_PREFETCH;
                CFD_STATE_PREFETCH: state_q <= CFD_STATE_RUN;
                CFD_STATE_RUN: state_q <= CFD_STATE_RUN;
                default: state_q <= CFD_STATE_RESET;
            endcase
        end
    end

    // next word read while current executes
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pc_q <= RESET_PC;
            instr_q <= 16'h0000;
            instr_valid_q <= 1'b0;
        end
        else
        begin
            instr_valid_q <= prog_rd;
            if (prog_rd)
            begin
                instr_q <= prog_data;
                pc_q <= pc_q + 24'h000001;
            end
        end
    end

    // register file and alu
    assign op_a = regs_q[exec_rd];
    assign op_b = exec_imm_sel ? exec_imm : regs_q[exec_rr];

    always_comb
    begin
        unique case (cfd_op_t'(exec_op))
            CFD_OP_ADD: res_d = {1'b0, op_a} + {1'b0, op_b};
            CFD_OP_SUB: res_d = {1'b0, op_a} - {1'b0, op_b};
            CFD_OP_AND: res_d = {1'b0, op_a & op_b};
            CFD_OP_OR: res_d = {1'b0, op_a | op_b};
            CFD_OP_XOR: res_d = {1'b0, op_a ^ op_b};
            CFD_OP_MOV: res_d = {1'b0, op_b};
            CFD_OP_INC: res_d = {1'b0, op_a + 8'h01};
            CFD_OP_DEC: res_d = {1'b0, op_a - 8'h01};
            CFD_OP_COM: res_d = {1'b1, ~op_a};
            default: res_d = {1'b0, op_a};
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs_q[i] <= 8'h00;
        end
        else if (exec_valid && (cfd_op_t'(exec_op) != CFD_OP_NOP))
            regs_q[exec_rd] <= res_d[7:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            flags_q <= RESET_FLAGS;
        else if (exec_valid && (cfd_op_t'(exec_op) != CFD_OP_NOP))
        begin
            flags_q[FLAG_C] <= res_d[8];
            flags_q[FLAG_Z] <= (res_d[7:0] == 8'h00);
            flags_q[FLAG_N] <= res_d[7];
            flags_q[FLAG_V] <= (op_a[7] ^ res_d[7]) & ~(op_a[7] ^ op_b[7]
                               ^ (cfd_op_t'(exec_op) == CFD_OP_SUB));
        end
    end

    // pointer pairs, low byte first
    always_comb
    begin
        unique case (ptr_sel)
            2'd0: ptr_idx = PTR_X_LO;
            2'd1: ptr_idx = PTR_Y_LO;
            default: ptr_idx = PTR_Z_LO;
        endcase
    end
    assign ptr_value = {regs_q[ptr_idx + 5'd1], regs_q[ptr_idx]};

    // data space decode, exactly one select per request that is not refused
    assign in_io = (data_addr <= IO_LAST);
    assign in_nvm = in_range(data_addr, NVM_WIN_FIRST, NVM_WIN_LAST);
    assign in_sram = in_range(data_addr, SRAM_FIRST, SRAM_LAST);
    // short io form only reaches the first 64
    assign data_refused = data_req && data_direct_io && (data_addr > IO_DIRECT_LAST);
    assign sel_io = data_req && !data_refused && in_io;
    assign sel_nvm_win = data_req && !data_refused && in_nvm;
    assign sel_sram = data_req && !data_refused && in_sram;
    assign sel_ext_ram = data_req && !data_refused && !in_io && !in_nvm && !in_sram;

    // store from boot section only, target not write locked
    assign store_lock = lock_for(self_program_store_op_addr, app_lock, table_lock, boot_lock);
    assign self_program_store_op_grant = self_program_store_op_req
                                         && (pc_q >= BOOT_FIRST) && (pc_q <= BOOT_LAST)
                                         && !store_lock[LOCK_WR] && !store_lock[LOCK_RW];

    a_one_select: assert property (@(posedge ref_clk) disable iff (reset)
        (data_req && !data_refused) |-> $onehot({sel_io, sel_nvm_win, sel_sram, sel_ext_ram}))
        else $error("region selects not one-hot");
    a_direct_io_span: assert property (@(posedge ref_clk) disable iff (reset)
        (data_req && data_direct_io && data_addr <= IO_DIRECT_LAST) |-> sel_io)
        else $error("direct io address not selected");
    a_ext_io_refused: assert property (@(posedge ref_clk) disable iff (reset)
        (data_req && data_direct_io && data_addr > IO_DIRECT_LAST) |-> !sel_io && data_refused)
        else $error("extended io reached by short form");
    a_nvm_window: assert property (@(posedge ref_clk) disable iff (reset)
        (data_req && !data_direct_io && data_addr[23:12] == 12'h001) |-> sel_nvm_win)
        else $error("nvm window not selected");
    a_sram_base: assert property (@(posedge ref_clk) disable iff (reset)
        (data_req && !data_direct_io && data_addr == SRAM_FIRST) |-> sel_sram && !sel_nvm_win)
        else $error("sram base wrong");
    a_io_bottom: assert property (@(posedge ref_clk) disable iff (reset)
        (data_req && !data_direct_io && data_addr[23:12] == 12'h000) |-> sel_io)
        else $error("io block not selected");
    a_prefetch_flow: assert property (@(posedge ref_clk) disable iff (reset)
        (prog_rd ##1 prog_rd) |-> pc_q == $past(pc_q) + 24'h000001)
        else $error("pc did not advance on fetch");
    a_fetch_answer: assert property (@(posedge ref_clk) disable iff (reset)
        prog_rd |=> instr_valid_q && instr_q == $past(prog_data))
        else $error("fetched word not taken");
    a_no_fetch_reset: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == CFD_STATE_RESET) |-> !prog_rd && !prog_rd_blocked)
        else $error("fetch issued before prefetch state");
    a_flag_zero: assert property (@(posedge ref_clk) disable iff (reset)
        (exec_valid && exec_op != CFD_OP_NOP && res_d[7:0] == 8'h00) |=> flags_q[FLAG_Z])
        else $error("zero flag not set");
    a_nop_ignored: assert property (@(posedge ref_clk) disable iff (reset)
        (exec_valid && exec_op == CFD_OP_NOP) |=> flags_q == $past(flags_q))
        else $error("nop changed flags");
    a_reg_write: assert property (@(posedge ref_clk) disable iff (reset)
        (exec_valid && exec_op == CFD_OP_MOV && exec_imm_sel) |=> regs_q[$past(exec_rd)]
        == $past(exec_imm))
        else $error("register not written in one cycle");
    a_store_boot_only: assert property (@(posedge ref_clk) disable iff (reset)
        self_program_store_op_grant |-> pc_q >= BOOT_FIRST && pc_q <= BOOT_LAST)
        else $error("store granted outside boot");
    a_store_locked: assert property (@(posedge ref_clk) disable iff (reset)
        (store_lock != 2'h0) |-> !self_program_store_op_grant)
        else $error("store granted into locked section");
    a_rw_lock_fetch: assert property (@(posedge ref_clk) disable iff (reset)
        (pc_q < APP_TABLE_FIRST && app_lock[LOCK_RW]) |-> !prog_rd)
        else $error("fetch from read locked section");
    a_table_lock_fetch: assert property (@(posedge ref_clk) disable iff (reset)
        (pc_q >= APP_TABLE_FIRST && pc_q < BOOT_FIRST && table_lock[LOCK_RW]) |-> !prog_rd)
        else $error("fetch from read locked table");
    a_boot_lock_fetch: assert property (@(posedge ref_clk) disable iff (reset)
        (pc_q >= BOOT_FIRST && boot_lock[LOCK_RW]) |-> !prog_rd)
        else $error("fetch from read locked boot");
    a_blocked_hold: assert property (@(posedge ref_clk) disable iff (reset)
        prog_rd_blocked |=> pc_q == $past(pc_q))
        else $error("pc moved on blocked fetch");

    c_ext_ram: cover property (@(posedge ref_clk) disable iff (reset) sel_ext_ram);
    c_store_granted: cover property (@(posedge ref_clk) disable iff (reset)
        self_program_store_op_grant);
    c_fetch_run: cover property (@(posedge ref_clk) disable iff (reset)
        instr_valid_q [*4]);
    c_refused: cover property (@(posedge ref_clk) disable iff (reset) data_refused);
endmodule
`default_nettype wire

// *** cfd_pkg.sv ***
// package of constants for the cpu fetch and data space map block
// Behaviour
// - separate buses for fetch and data
// - prefetch next instruction during execute
// - thirty-two byte registers, single cycle access
// - six registers pair into three pointers
// - two-register, immediate, single-register ops, one cycle
// - flags updated after every operation except nop
// - peripheral registers in lowest 4KB
// - first 64 I/O reachable two ways
// - extended I/O only via data loads/stores
// - 0x1000-0x1FFF reserved nonvolatile window
// - SRAM from 0x2000, external RAM above
// - never fetch from SRAM
// - 24-bit program and data addresses
// - app and boot sections with locks
// - table sub-section has own locks
// - self-program store only from boot
package cfd_pkg;
    localparam int ADDR_W = 24;
    localparam int NUM_REGS = 32;
    localparam logic [23:0] IO_DIRECT_LAST = 24'h00003F;
    localparam logic [23:0] IO_LAST = 24'h000FFF;
    localparam logic [23:0] NVM_WIN_FIRST = 24'h001000;
    localparam logic [23:0] NVM_WIN_LAST = 24'h001FFF;
    localparam logic [23:0] SRAM_FIRST = 24'h002000;
    // internal sram size, plain default
    localparam logic [23:0] SRAM_LAST = 24'h003FFF;
    // program word address section boundaries, plain defaults
    localparam logic [23:0] APP_TABLE_FIRST = 24'h00F000;
    localparam logic [23:0] BOOT_FIRST = 24'h010000;
    localparam logic [23:0] BOOT_LAST = 24'h010FFF;
    // pointer pair base indices
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;
    // flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    // lock field: bit0 blocks write, bit1 blocks read and write
    localparam int LOCK_WR = 0;
    localparam int LOCK_RW = 1;
    localparam logic [7:0] RESET_FLAGS = 8'h00;
    localparam logic [23:0] RESET_PC = 24'h000000;
    typedef enum logic [3:0]
    {
        CFD_OP_ADD = 4'h0,
        CFD_OP_SUB = 4'h1,
        CFD_OP_AND = 4'h2,
        CFD_OP_OR = 4'h3,
        CFD_OP_XOR = 4'h4,
        CFD_OP_MOV = 4'h5,
        CFD_OP_INC = 4'h6,
        CFD_OP_DEC = 4'h7,
        CFD_OP_COM = 4'h8,
        CFD_OP_NOP = 4'hF
    } cfd_op_t;
    typedef enum logic [1:0]
    {
        CFD_STATE_RESET = 2'h0,
        CFD_STATE_PREFETCH = 2'h1,
        CFD_STATE_RUN = 2'h3
    } cfd_state_t;
endpackage

// *** cfd_prog_model.sv ***
// program memory model answering instruction fetches
`timescale 1ns/1ps
`default_nettype none
module cfd_prog_model (
    input wire logic ref_clk,
    input wire logic [23:0] prog_addr,
    input wire logic prog_rd,
    output logic [15:0] prog_data
);
    logic [15:0] last_q = 16'h0000;
    always_comb
    begin
        if (prog_rd)
            prog_data = {prog_addr[7:0] ^ 8'hA5, prog_addr[15:8]};
        else
            prog_data = ~last_q;
    end
    always @(posedge ref_clk)
    begin
        if (prog_rd)
            last_q <= prog_data;
    end
endmodule
`default_nettype wire

// *** cfd_tb.sv ***
// self-checking bench for the fetch and data space map block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cfd_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [23:0] prog_addr, data_addr = 24'h000000, self_program_store_op_addr = 24'h000000;
    logic [15:0] prog_data, ptr_value, instr_q;
    logic [1:0] app_lock = 2'h0, table_lock = 2'h0, boot_lock = 2'h0, ptr_sel = 2'h0;
    logic [7:0] exec_imm = 8'h00, flags_q;
    logic [4:0] exec_rd = 5'h00, exec_rr = 5'h00;
    logic [3:0] exec_op = 4'hF;
    logic prog_rd, exec_valid = 1'b0, exec_imm_sel = 1'b0, data_req = 1'b0;
    logic data_direct_io = 1'b0, self_program_store_op_req = 1'b0;
    logic sel_io, sel_nvm_win, sel_sram, sel_ext_ram;
    logic data_refused, self_program_store_op_grant, prog_rd_blocked, instr_valid_q;
    int num_errors = 0;
    int checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    cfd_core dut (.ref_clk, .reset, .prog_addr, .prog_rd, .prog_data, .app_lock, .table_lock,
        .boot_lock, .exec_valid, .exec_op, .exec_imm_sel, .exec_imm, .exec_rd, .exec_rr,
        .ptr_sel, .ptr_value, .data_addr, .data_req, .data_direct_io, .sel_io, .sel_nvm_win,
        .sel_sram, .sel_ext_ram, .data_refused, .self_program_store_op_req,
        .self_program_store_op_addr, .self_program_store_op_grant,
        .prog_rd_blocked, .instr_q, .instr_valid_q, .flags_q);
    cfd_prog_model flash (.ref_clk, .prog_addr, .prog_rd, .prog_data);
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic op(input logic [3:0] o, input logic [4:0] rd, input logic [4:0] rr,
        input logic s, input logic [7:0] imm);
        exec_valid = 1'b1;
        exec_op = o;
        exec_rd = rd;
        exec_rr = rr;
        exec_imm_sel = s;
        exec_imm = imm;
        @(negedge ref_clk);
    endtask
    task automatic wait_pc(input logic [23:0] a);
        int n;
        n = 0;
        while (prog_addr !== a && n < 70000)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(prog_addr, a, "pc never reached target");
    endtask
    task automatic t_fetch();
        logic [23:0] a;
        repeat (3) @(negedge ref_clk);
        repeat (4)
        begin
            a = prog_addr - 24'h000001;
            chk(prog_rd, 1'b1, "fetch not issued");
            chk(instr_valid_q, 1'b1, "no valid word");
            chk(instr_q, {a[7:0] ^ 8'hA5, a[15:8]}, "wrong word");
            @(negedge ref_clk);
        end
        $display("test fetch done");
    endtask
    task automatic t_lock();
        logic [23:0] a;
        app_lock = 2'h2;
        #1;
        a = prog_addr;
        chk({prog_rd, prog_rd_blocked}, 2'b01, "read lock ignored");
        @(negedge ref_clk);
        chk(prog_addr, a, "pc moved while locked");
        app_lock = 2'h1;
        #1 chk(prog_rd, 1'b1, "write lock blocked fetch");
        @(negedge ref_clk);
        app_lock = 2'h0;
        table_lock = 2'h2;
        #1 chk(prog_rd, 1'b1, "table lock hit app code");
        @(negedge ref_clk);
        table_lock = 2'h0;
        $display("test lock done");
    endtask
    task automatic t_alu();
        op(CFD_OP_MOV, 5'h1E, 5'h00, 1'b1, 8'h80);
        op(CFD_OP_ADD, 5'h1E, 5'h00, 1'b1, 8'h80);
        ptr_sel = 2'h3;
        #1 chk(ptr_value, 16'h0000, "add result");
        chk(flags_q[3:0], 4'hB, "add flags");
        op(CFD_OP_MOV, 5'h1C, 5'h00, 1'b1, 8'h05);
        op(CFD_OP_MOV, 5'h1D, 5'h00, 1'b1, 8'h03);
        op(CFD_OP_SUB, 5'h1C, 5'h1D, 1'b0, 8'hFF);
        ptr_sel = 2'h1;
        #1 chk(ptr_value, 16'h0302, "sub result");
        chk(flags_q[3:0], 4'h0, "sub flags");
        op(CFD_OP_COM, 5'h1D, 5'h00, 1'b0, 8'h00);
        op(CFD_OP_NOP, 5'h1D, 5'h00, 1'b1, 8'h00);
        #1 chk(ptr_value, 16'hFC02, "com or nop result");
        chk(flags_q[2:1], 2'b10, "com flags");
        op(CFD_OP_MOV, 5'h1A, 5'h00, 1'b1, 8'hFF);
        op(CFD_OP_INC, 5'h1A, 5'h00, 1'b1, 8'h00);
        exec_valid = 1'b0;
        ptr_sel = 2'h0;
        #1 chk(ptr_value, 16'h0000, "inc result");
        chk(flags_q[1], 1'b1, "inc zero flag");
        op(CFD_OP_DEC, 5'h1A, 5'h00, 1'b1, 8'h00);
        op(CFD_OP_AND, 5'h1A, 5'h00, 1'b1, 8'h3C);
        op(CFD_OP_OR, 5'h1A, 5'h00, 1'b1, 8'h41);
        op(CFD_OP_XOR, 5'h1A, 5'h00, 1'b1, 8'hFF);
        exec_valid = 1'b0;
        #1 chk(ptr_value, 16'h0082, "logic ops result");
        chk(flags_q[2:0], 3'h4, "logic ops flags");
        $display("test alu done");
    endtask
    task automatic t_decode();
        logic [23:0] da [10] = '{24'h000000, 24'h00003F, 24'h000040, 24'h000FFF, 24'h001000,
            24'h001FFF, 24'h002000, 24'h003FFF, 24'h004000, 24'hFFFFFF};
        logic [3:0] de [10] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1};
        data_req = 1'b1;
        for (int i = 0; i < 13; i++)
        begin
            @(negedge ref_clk);
            data_addr = da[i % 10];
            data_direct_io = (i >= 10);
            #1 chk(data_refused, (i == 12), "refusal");
            chk({sel_io, sel_nvm_win, sel_sram, sel_ext_ram}, (i == 12) ? 4'h0 : de[i % 10],
                "selects");
        end
        data_req = 1'b0;
        $display("test decode done");
    endtask
    task automatic t_store_op();
        self_program_store_op_req = 1'b1;
        self_program_store_op_addr = 24'h000100;
        #1 chk(self_program_store_op_grant, 1'b0, "store from app");
        wait_pc(APP_TABLE_FIRST);
        table_lock = 2'h2;
        #1 chk(prog_rd_blocked, 1'b1, "table read lock");
        @(negedge ref_clk);
        table_lock = 2'h0;
        wait_pc(BOOT_FIRST);
        chk(self_program_store_op_grant, 1'b1, "store from boot");
        app_lock = 2'h1;
        #1 chk(self_program_store_op_grant, 1'b0, "app write lock");
        self_program_store_op_addr = APP_TABLE_FIRST;
        #1 chk(self_program_store_op_grant, 1'b1, "table under app lock");
        app_lock = 2'h0;
        table_lock = 2'h1;
        #1 chk(self_program_store_op_grant, 1'b0, "table write lock");
        @(negedge ref_clk);
        table_lock = 2'h0;
        boot_lock = 2'h2;
        #1 chk(prog_rd_blocked, 1'b1, "boot read lock");
        self_program_store_op_req = 1'b0;
        $display("test store op done");
    endtask
    initial
    begin
        repeat (6) @(negedge ref_clk);
        chk(prog_addr, RESET_PC, "reset address");
        chk(prog_rd, 1'b0, "reset fetch");
        reset = 1'b0;
        t_fetch();
        t_lock();
        t_alu();
        t_decode();
        t_store_op();
        final_report();
    end
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        num_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        final_report();
    end
endmodule
`default_nettype wire
